/* File: uisc_top.sv */
// Interrupt status and clear register of the serial bridge.
// Operation
// - Reachable only with bank value and enable bit.
// - Register resets to all zeros.
// - Bit 7 shows handshake change interrupt.
// - Bit 6 shows flow-off or special character.
// - Bit 5 shows modem interrupt.
// - Bit 4 shows transmit holding interrupt.
// - Bit 3 shows receiver timeout interrupt.
// - Bit 2 shows receive holding interrupt.
// - Bit 1 shows receive line error.
// - Writing one to bit 0 clears status.
// - Bit 0 returns to zero by itself.
`timescale 1ns/1ps
module uisc_top
  import uisc_pkg::*;
(
  input wire logic clk_in, // UART clock.
  input wire logic reset_n_in, // Asynchronous reset, active low.
  input wire logic [3:0] reg_addr_in, // Register offset from the host port.
  input wire logic reg_wr_in, // One-cycle write strobe.
  input wire logic reg_rd_in, // One-cycle read strobe.
  input wire logic [7:0] reg_wdata_in, // Write data.
  input wire logic [7:0] line_control_reg_in, // Current line control register value.
  input wire logic [7:0] special_function_reg_in, // Current special function register value.
  input wire logic [UISC_NSRC-1:0] src_event_in, // Source pulses, bit 0 maps to status bit 1.
  output logic [7:0] reg_rdata_out, // Read data, registered.
  output logic reg_rvalid_out, // One-cycle pulse with read data.
  output logic [7:0] status_out, // Live register contents.
  output logic clear_all_status_out // One-cycle pulse when status is wiped.
);
  // All state of the block in one struct.
  typedef struct packed {
    logic [7:0] isc; // Register contents.
    logic [7:0] rdata; // Read data.
    logic rvalid; // Read answer pulse.
    logic clr; // Clear pulse.
  } uisc_state_t;

  uisc_state_t s_q; // Registered state.
  uisc_state_t s_d; // Next state.
  logic bank_open; // Access enable for this register.
  logic sel; // Register is addressed and reachable.

  // Bank decode: the register is selected only in the special bank.
  assign bank_open = (line_control_reg_in == UISC_LINE_CTRL_BANK) &&
                     special_function_reg_in[UISC_SPECIAL_EN_BIT];
  assign sel = bank_open && (reg_addr_in == UISC_OFFSET_ISC);

  // Next-state logic for status bits, clear command and read port.
  always_comb begin
    logic do_clr;
    do_clr = 1'b0;
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.clr = 1'b0;
    s_d.isc[UISC_BIT_CLR] = 1'b0;
    if (sel && reg_wr_in) begin
      // Software may write the status bits directly.
      s_d.isc[7:1] = reg_wdata_in[7:1];
      if (reg_wdata_in[UISC_BIT_CLR]) begin
        do_clr = 1'b1;
      end
    end
    if (do_clr) begin
      // Clear wipes every status bit.
      s_d.isc[7:1] = '0;
      s_d.clr = 1'b1;
    end
    // Sources set their bits; a set beats a clear in the same cycle.
    s_d.isc[UISC_BIT_LERR] = s_d.isc[UISC_BIT_LERR] | src_event_in[0];
    s_d.isc[UISC_BIT_RXH] = s_d.isc[UISC_BIT_RXH] | src_event_in[1];
    s_d.isc[UISC_BIT_RXTO] = s_d.isc[UISC_BIT_RXTO] | src_event_in[2];
    s_d.isc[UISC_BIT_TXH] = s_d.isc[UISC_BIT_TXH] | src_event_in[3];
    s_d.isc[UISC_BIT_MODEM] = s_d.isc[UISC_BIT_MODEM] | src_event_in[4];
    s_d.isc[UISC_BIT_XOFF] = s_d.isc[UISC_BIT_XOFF] | src_event_in[5];
    s_d.isc[UISC_BIT_HSK] = s_d.isc[UISC_BIT_HSK] | src_event_in[6];
    if (reg_rd_in) begin
      // Reads outside the bank return zero.
      s_d.rvalid = 1'b1;
      s_d.rdata = sel ? s_q.isc : 8'h00;
    end
  end

  // State register with asynchronous reset.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '{isc: UISC_RESET_VAL, rdata: 8'h00, rvalid: 1'b0, clr: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_out = s_q.rdata;
  assign reg_rvalid_out = s_q.rvalid;
  assign status_out = s_q.isc;
  assign clear_all_status_out = s_q.clr;

  // Reads outside the bank must return zero.
  property p_bank;
    @(posedge clk_in) disable iff (!reset_n_in)
      (reg_rd_in && !bank_open) |=> (reg_rvalid_out && reg_rdata_out == 8'h00);
  endproperty
  a_bank: assert property (p_bank) else $error("read outside bank not zero");

  // Status and both pulses are zero right after reset release.
  property p_reset;
    @(posedge clk_in) $rose(reset_n_in) |->
      (status_out == UISC_RESET_VAL) && !reg_rvalid_out && !clear_all_status_out;
  endproperty
  a_reset: assert property (p_reset) else $error("status not zero after reset");

  // A handshake change event sets bit 7 on the next edge.
  property p_hsk;
    @(posedge clk_in) disable iff (!reset_n_in) src_event_in[6] |=> status_out[UISC_BIT_HSK];
  endproperty
  a_hsk: assert property (p_hsk) else $error("handshake bit not set");

  // A flow-off or special character event sets bit 6 on the next edge.
  property p_xoff;
    @(posedge clk_in) disable iff (!reset_n_in) src_event_in[5] |=> status_out[UISC_BIT_XOFF];
  endproperty
  a_xoff: assert property (p_xoff) else $error("flow-off bit not set");

  // A modem status event sets bit 5 on the next edge.
  property p_modem;
    @(posedge clk_in) disable iff (!reset_n_in) src_event_in[4] |=> status_out[UISC_BIT_MODEM];
  endproperty
  a_modem: assert property (p_modem) else $error("modem bit not set");

  // A transmit holding event sets bit 4 on the next edge.
  property p_txh;
    @(posedge clk_in) disable iff (!reset_n_in) src_event_in[3] |=> status_out[UISC_BIT_TXH];
  endproperty
  a_txh: assert property (p_txh) else $error("transmit bit not set");

  // A receiver timeout event sets bit 3 on the next edge.
  property p_rxto;
    @(posedge clk_in) disable iff (!reset_n_in) src_event_in[2] |=> status_out[UISC_BIT_RXTO];
  endproperty
  a_rxto: assert property (p_rxto) else $error("timeout bit not set");

  // A receive holding event sets bit 2 on the next edge.
  property p_rxh;
    @(posedge clk_in) disable iff (!reset_n_in) src_event_in[1] |=> status_out[UISC_BIT_RXH];
  endproperty
  a_rxh: assert property (p_rxh) else $error("receive bit not set");

  // A receive line error event sets bit 1 on the next edge.
  property p_lerr;
    @(posedge clk_in) disable iff (!reset_n_in) src_event_in[0] |=> status_out[UISC_BIT_LERR];
  endproperty
  a_lerr: assert property (p_lerr) else $error("line error bit not set");

  // A clearing write with no new events leaves all status low and pulses clear.
  sequence s_clear_write;
    sel && reg_wr_in && reg_wdata_in[UISC_BIT_CLR] && (src_event_in == '0);
  endsequence
  property p_clear;
    @(posedge clk_in) disable iff (!reset_n_in)
      s_clear_write |=> (status_out == 8'h00 && clear_all_status_out);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not wipe status");

  // Bit 0 reads zero on the cycle after a clearing write reached the register.
  sequence s_clear_cmd;
    sel && reg_wr_in && reg_wdata_in[UISC_BIT_CLR];
  endsequence
  property p_selfclr;
    @(posedge clk_in) disable iff (!reset_n_in) s_clear_cmd |=> !status_out[UISC_BIT_CLR];
  endproperty
  a_selfclr: assert property (p_selfclr) else $error("clear bit stuck high");

  // The clear pulse appears only after a clearing write that reached the register.
  property p_clr_only;
    @(posedge clk_in) disable iff (!reset_n_in)
      !(sel && reg_wr_in && reg_wdata_in[UISC_BIT_CLR]) |=> !clear_all_status_out;
  endproperty
  a_clr_only: assert property (p_clr_only) else $error("clear pulse without command");

  // Every read strobe is answered by a valid pulse on the next cycle.
  property p_rvalid;
    @(posedge clk_in) disable iff (!reset_n_in) reg_rd_in |=> reg_rvalid_out;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");

  // No valid pulse appears without a read strobe one cycle before.
  property p_no_rvalid;
    @(posedge clk_in) disable iff (!reset_n_in) !reg_rd_in |=> !reg_rvalid_out;
  endproperty
  a_no_rvalid: assert property (p_no_rvalid) else $error("answer without read");

  // Read data holds its value until the next read strobe.
  property p_rdata_hold;
    @(posedge clk_in) disable iff (!reset_n_in) !reg_rd_in |=> $stable(reg_rdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  // A read inside the bank returns the register as it stood at the strobe.
  sequence s_read_in_bank;
    sel && reg_rd_in;
  endsequence
  property p_rdata;
    @(posedge clk_in) disable iff (!reset_n_in)
      s_read_in_bank |=> (reg_rdata_out == $past(status_out));
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data differs from register");

  // A plain write inside the bank stores bits 7 to 1 and leaves bit 0 low.
  sequence s_store_write;
    sel && reg_wr_in && !reg_wdata_in[UISC_BIT_CLR] && (src_event_in == '0);
  endsequence
  property p_store;
    @(posedge clk_in) disable iff (!reset_n_in)
      s_store_write |=> ((status_out >> 1) == ($past(reg_wdata_in) >> 1)) &&
        !status_out[UISC_BIT_CLR];
  endproperty
  a_store: assert property (p_store) else $error("write did not store bits");

  // Without a write that reaches the register or an event, the status bits stay put.
  property p_hold;
    @(posedge clk_in) disable iff (!reset_n_in)
      (!(sel && reg_wr_in) && (src_event_in == '0)) |=> $stable(status_out);
  endproperty
  a_hold: assert property (p_hold) else $error("status changed by itself");
endmodule : uisc_top

/* File: uisc_pkg.sv */
// Package with offsets, field positions and reset values of the interrupt status register.
package uisc_pkg;
  localparam logic [3:0] UISC_OFFSET_ISC = 4'hF; // Offset of interrupt_status_clear.
  localparam logic [7:0] UISC_LINE_CTRL_BANK = 8'hBF; // Line control value that opens the bank.
  localparam int UISC_SPECIAL_EN_BIT = 2; // Special function bit that enables access.
  localparam logic [7:0] UISC_RESET_VAL = 8'h00; // Reset value of the register.
  localparam int UISC_BIT_HSK = 7; // Handshake line change source.
  localparam int UISC_BIT_XOFF = 6; // Flow-off or special character source.
  localparam int UISC_BIT_MODEM = 5; // Modem status source.
  localparam int UISC_BIT_TXH = 4; // Transmit holding source.
  localparam int UISC_BIT_RXTO = 3; // Receiver timeout source.
  localparam int UISC_BIT_RXH = 2; // Receive holding source.
  localparam int UISC_BIT_LERR = 1; // Receive line error source.
  localparam int UISC_BIT_CLR = 0; // Self-clearing clear command.
  localparam int UISC_NSRC = 7; // Number of interrupt sources.
endpackage : uisc_pkg

/* File: tb_top.sv */
// Self-checking testbench for the interrupt status and clear register.
`timescale 1ns/1ps
module tb_top;
  import uisc_pkg::*;
  logic clk_in = 1'b0; // Block clock, 5 ns period.
  logic reset_n_in = 1'b0; // Reset, active low.
  logic [3:0] reg_addr_in = UISC_OFFSET_ISC; // Register offset.
  logic reg_wr_in = 1'b0; // Write strobe.
  logic reg_rd_in = 1'b0; // Read strobe.
  logic [7:0] reg_wdata_in = 8'h00; // Write data.
  logic [7:0] line_control_reg_in = UISC_LINE_CTRL_BANK; // Bank selection value.
  logic [7:0] special_function_reg_in = 8'h04; // Access enable lives in bit 2.
  logic [UISC_NSRC-1:0] src_event_in = '0; // Source pulses.
  logic [7:0] reg_rdata_out; // Read data.
  logic reg_rvalid_out; // Read answer pulse.
  logic [7:0] status_out; // Live register contents.
  logic clear_all_status_out; // Clear pulse.
  logic [7:0] rd_q; // Last value read back.
  logic [7:0] exp_q; // Expected sticky status.
  int errors = 0; // Mismatch counter.
  int cmp_count = 0; // Comparison counter.
  always #2.5 clk_in = ~clk_in;
  uisc_top i_uisc_top (.clk_in, .reset_n_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
    .line_control_reg_in, .special_function_reg_in, .src_event_in, .reg_rdata_out,
    .reg_rvalid_out, .status_out, .clear_all_status_out);
  // Compares one byte and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Reads the register; the answer arrives one cycle after the strobe.
  task automatic reg_read();
    @(posedge clk_in) reg_rd_in <= 1'b1;
    @(posedge clk_in) reg_rd_in <= 1'b0;
    #1;
    chk({7'h00, reg_rvalid_out}, 8'h01);
    rd_q = reg_rdata_out;
  endtask : reg_read
  // Writes one byte with the present bank and offset settings.
  task automatic reg_write(input logic [7:0] d);
    @(posedge clk_in) begin
      reg_wr_in <= 1'b1;
      reg_wdata_in <= d;
    end
    @(posedge clk_in) reg_wr_in <= 1'b0;
    #1;
  endtask : reg_write
  // Pulses one source for a single cycle.
  task automatic pulse(input int i);
    @(posedge clk_in) src_event_in <= 7'(1 << i);
    @(posedge clk_in) src_event_in <= '0;
    #1;
  endtask : pulse
  // Checks the value left by reset.
  task automatic test_reset();
    chk(status_out, UISC_RESET_VAL);
    reg_read();
    chk(rd_q, UISC_RESET_VAL);
    $display("test_reset done");
  endtask : test_reset
  // Raises every source in turn; each lands on its own bit and sticks.
  task automatic test_sources();
    exp_q = 8'h00;
    for (int i = 0; i < UISC_NSRC; i++) begin
      pulse(i);
      exp_q = exp_q | 8'(2 << i);
      reg_read();
      chk(rd_q, exp_q);
    end
    $display("test_sources done");
  endtask : test_sources
  // Clears all status with bit 0 and checks that bit 0 falls back.
  task automatic test_clear();
    reg_write(8'h01);
    chk({7'h00, clear_all_status_out}, 8'h01);
    chk(status_out, 8'h00);
    @(posedge clk_in) #1;
    chk({7'h00, clear_all_status_out}, 8'h00);
    reg_read();
    chk(rd_q, 8'h00);
    $display("test_clear done");
  endtask : test_clear
  // Tries a clear under one access setting and checks the result.
  task automatic try_clear(input logic [7:0] line_ctrl, input logic [7:0] special_fn,
      input logic [3:0] addr, input logic [7:0] exp);
    @(posedge clk_in) begin
      line_control_reg_in <= line_ctrl;
      special_function_reg_in <= special_fn;
      reg_addr_in <= addr;
    end
    reg_write(8'h01);
    chk(status_out, exp);
  endtask : try_clear
  // Access is refused unless the bank value and the enable bit are both set.
  task automatic test_bank();
    pulse(6);
    try_clear(8'hBE, 8'h04, UISC_OFFSET_ISC, 8'h80);
    reg_read();
    chk(rd_q, 8'h00);
    try_clear(UISC_LINE_CTRL_BANK, 8'hFB, UISC_OFFSET_ISC, 8'h80);
    try_clear(UISC_LINE_CTRL_BANK, 8'h04, 4'hE, 8'h80);
    try_clear(UISC_LINE_CTRL_BANK, 8'h04, UISC_OFFSET_ISC, 8'h00);
    $display("test_bank done");
  endtask : test_bank
  // A plain write stores bits 7 to 1; a write with bit 0 set wipes them instead.
  task automatic test_write();
    reg_write(8'hA4);
    chk(status_out, 8'hA4);
    reg_read();
    chk(rd_q, 8'hA4);
    reg_write(8'hFF);
    chk(status_out, 8'h00);
    $display("test_write done");
  endtask : test_write
  // Source events beat a clearing write and a written zero in the same cycle.
  task automatic test_set_wins();
    @(posedge clk_in) begin
      reg_wr_in <= 1'b1;
      reg_wdata_in <= 8'h01;
      src_event_in <= 7'h08;
    end
    @(posedge clk_in) begin
      reg_wdata_in <= 8'h00;
      src_event_in <= 7'h10;
    end
    #1;
    chk(status_out, 8'h10);
    chk({7'h00, clear_all_status_out}, 8'h01);
    @(posedge clk_in) begin
      reg_wr_in <= 1'b0;
      src_event_in <= '0;
    end
    #1;
    chk(status_out, 8'h20);
    $display("test_set_wins done");
  endtask : test_set_wins
  // A reset in mid-run wipes the register, and reads answer again after it.
  task automatic test_midreset();
    @(posedge clk_in) reset_n_in <= 1'b0;
    @(posedge clk_in) #1;
    chk(status_out, UISC_RESET_VAL);
    @(posedge clk_in) reset_n_in <= 1'b1;
    @(posedge clk_in) #1;
    chk(status_out, UISC_RESET_VAL);
    chk({7'h00, clear_all_status_out}, 8'h00);
    reg_read();
    chk(rd_q, UISC_RESET_VAL);
    $display("test_midreset done");
  endtask : test_midreset
  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // Main sequence: reset for five cycles, then the scenarios.
  initial begin
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in) #1;
    test_reset();
    test_sources();
    test_clear();
    test_bank();
    test_write();
    test_set_wins();
    test_midreset();
    complete_run();
  end
endmodule : tb_top
